// File: inc/bank_sel_pkg.sv
// Shared constants and types for the parameter bank selector
`default_nettype none
package bank_sel_pkg;
  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int NB = 8;
  localparam int BW = 3;
  localparam int CW = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int EW = 5;

  // ----------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------
  localparam logic [AW-1:0] ADR_CTRL   = 8'h00;
  localparam logic [AW-1:0] ADR_FORCE  = 8'h04;
  localparam logic [AW-1:0] ADR_REMOTE = 8'h08;
  localparam logic [AW-1:0] ADR_ACTIVE = 8'h0C;
  localparam logic [AW-1:0] ADR_EVT    = 8'h10;
  localparam logic [AW-1:0] ADR_MASK   = 8'h14;

  // ----------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------
  localparam int CTRL_FEN = 0;
  localparam int CTRL_CNT = 4;
  localparam logic [CW-1:0] CODE_NONE = 4'h0;
  localparam logic [CW-1:0] CODE_MAX  = 4'h8;
  localparam logic [CW-1:0] CODE_STEP = 4'h1;
  localparam logic [BW-1:0] BANK_ONE  = 3'h0;
  localparam logic [NB-1:0] EN_RESET  = 8'h01;

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef struct packed {
    logic [BW-1:0] used_cnt;
    logic          force_enable;
  } cfg_t;

  typedef struct packed {
    logic enable_chg;
    logic active_chg;
    logic prio_fail;
    logic force_fail;
    logic cfg_fail;
  } evt_t;

  typedef struct packed {
    logic          hit;
    logic [BW-1:0] idx;
  } pick_t;
endpackage
`default_nettype wire

// File: logic/parameter_bank_selector.sv
// Priority selector for the active parameter bank, Avalon-MM slave
//
// Operation
// - Force needs force_enable and enabled bank
// - Force target 0 none, 1..8 banks
// - Force acts as pulse; last bank stays
// - Panel/remote changes rejected without force_enable
// - force_enable ignores request inputs until cleared
// - Used count 0 only bank one, up
// - Newly enabled banks load default parameters
// - Remote field 0 none, 1..8, resets 0
// - Remote blocked by higher held request
// - Static levels retake control after force release
// - Active bank readable, bank one after reset
// - Eight one-bit requests, pulse or level
// - Bank one held blocks all others
// - Held bank blocks lower, not higher
// - Bank eight held blocks nothing
// - Pulse-selected bank stays until another request
// - Request to disabled bank flags failure
// - Blocked request flags failure, no change
//
// Register access over Avalon-MM and the address map were decided locally.
`default_nettype none
module parameter_bank_selector (
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  input  wire logic [bank_sel_pkg::NB-1:0]     bank_req,
  input  wire logic [bank_sel_pkg::AW-1:0]     avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [bank_sel_pkg::DW-1:0]     avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic      [bank_sel_pkg::DW-1:0]     avs_readdata,
  output logic                                 avs_waitrequest,
  output logic      [bank_sel_pkg::BW-1:0]     active_bank,
  output logic      [bank_sel_pkg::NB-1:0]     bank_defaults_load,
  output logic                                 irq
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [bank_sel_pkg::NB-1:0] sync1_q;
  logic [bank_sel_pkg::NB-1:0] sync2_q;
  logic [bank_sel_pkg::NB-1:0] prev_q;
  bank_sel_pkg::cfg_t          cfg_q;
  logic                        fen_prev_q;
  logic [bank_sel_pkg::CW-1:0] force_code_q;
  logic [bank_sel_pkg::CW-1:0] remote_code_q;
  logic [bank_sel_pkg::BW-1:0] active_q;
  logic [bank_sel_pkg::BW-1:0] active_d;
  logic [bank_sel_pkg::NB-1:0] en_q;
  logic [bank_sel_pkg::NB-1:0] load_q;
  bank_sel_pkg::evt_t          evt_q;
  bank_sel_pkg::evt_t          evt_set;
  logic [bank_sel_pkg::EW-1:0] evt_clr;
  logic [bank_sel_pkg::EW-1:0] mask_q;
  logic                        irq_q;
  logic                        wait_q;
  logic [bank_sel_pkg::DW-1:0] rdata_q;
  logic [bank_sel_pkg::DW-1:0] rdata_mux;

  // ----------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------
  logic [bank_sel_pkg::NB-1:0] rise;
  logic [bank_sel_pkg::NB-1:0] held;
  logic [bank_sel_pkg::NB-1:0] en;
  logic [bank_sel_pkg::NB-1:0] hh;
  logic [bank_sel_pkg::NB-1:0] pin_ok;
  logic                        wr_go;
  logic                        rd_go;
  logic                        fen;

  // Pulse start is a rising edge; a level counts as held from its second cycle
  assign rise = sync2_q & ~prev_q;
  assign held = sync2_q & prev_q;
  assign fen  = cfg_q.force_enable;
  assign hh[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < bank_sel_pkg::NB; gi++) begin : g_bank
      assign en[gi] = (gi <= int'(cfg_q.used_cnt));
      if (gi > 0) begin : g_hh
        // Bank eight is never above anyone, so its hold blocks nothing
        assign hh[gi] = hh[gi-1] | held[gi-1];
      end
    end
  endgenerate

  assign pin_ok = rise & en & ~hh;

  function automatic bank_sel_pkg::pick_t first_set(
    input logic [bank_sel_pkg::NB-1:0] v
  );
    bank_sel_pkg::pick_t p;
    p = '0;
    for (int i = bank_sel_pkg::NB - 1; i >= 0; i--) begin
      if (v[i]) begin
        p.hit = 1'b1;
        p.idx = bank_sel_pkg::BW'(i);
      end
    end
    return p;
  endfunction

  function automatic logic code_ok(input logic [bank_sel_pkg::CW-1:0] c);
    return (c != bank_sel_pkg::CODE_NONE) && (c <= bank_sel_pkg::CODE_MAX);
  endfunction

  function automatic logic [bank_sel_pkg::BW-1:0] code_idx(
    input logic [bank_sel_pkg::CW-1:0] c
  );
    logic [bank_sel_pkg::CW-1:0] t;
    t = c - bank_sel_pkg::CODE_STEP;
    return t[bank_sel_pkg::BW-1:0];
  endfunction

  // ----------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------
  assign wr_go = avs_write & ~wait_q & avs_byteenable[0];
  assign rd_go = avs_read & wait_q;

  logic [bank_sel_pkg::CW-1:0] wcode;
  logic                        wr_force;
  logic                        wr_remote;
  assign wcode     = avs_writedata[bank_sel_pkg::CW-1:0];
  assign wr_force  = wr_go && (avs_address == bank_sel_pkg::ADR_FORCE);
  assign wr_remote = wr_go && (avs_address == bank_sel_pkg::ADR_REMOTE);

  // ----------------------------------------------------------
  // Selection
  // ----------------------------------------------------------
  bank_sel_pkg::pick_t pin_pick;
  bank_sel_pkg::pick_t hold_pick;
  assign pin_pick  = first_set(pin_ok);
  assign hold_pick = first_set(held & en);

  always_comb begin
    logic [bank_sel_pkg::BW-1:0] ti;
    ti       = code_idx(wcode);
    active_d = active_q;
    evt_set  = '0;
    if ((wr_force || wr_remote) && (wcode != bank_sel_pkg::CODE_NONE)) begin
      if (!fen) begin
        evt_set.force_fail = 1'b1;
      end else if (!code_ok(wcode) || !en[ti]) begin
        evt_set.cfg_fail = 1'b1;
      end else if (wr_remote && hh[ti]) begin
        evt_set.prio_fail = 1'b1;
      end else begin
        // One-shot change; nothing re-applies it later
        active_d = ti;
      end
    end else if (fen_prev_q && !fen && hold_pick.hit) begin
      active_d = hold_pick.idx;
    end else if (!fen) begin
      // Pin edges are only looked at while forcing is off
      evt_set.cfg_fail  = |(rise & ~en);
      evt_set.prio_fail = |(rise & en & hh);
      if (pin_pick.hit) begin
        active_d = pin_pick.idx;
      end
    end
    evt_set.active_chg = (active_d != active_q);
    evt_set.enable_chg = (en != en_q);
  end

  // ----------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= bank_req;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ----------------------------------------------------------
  // Active bank
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      active_q   <= bank_sel_pkg::BANK_ONE;
      fen_prev_q <= 1'b0;
    end else begin
      active_q   <= active_d;
      fen_prev_q <= fen;
    end
  end

  // ----------------------------------------------------------
  // Enabled set and default load strobe
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      en_q   <= bank_sel_pkg::EN_RESET;
      load_q <= '0;
    end else begin
      en_q   <= en;
      load_q <= en & ~en_q;
    end
  end

  // ----------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_q         <= '0;
      force_code_q  <= bank_sel_pkg::CODE_NONE;
      remote_code_q <= bank_sel_pkg::CODE_NONE;
      mask_q        <= '0;
    end else if (wr_go) begin
      case (avs_address)
        bank_sel_pkg::ADR_CTRL: begin
          // Override stays until software writes the bit low
          cfg_q.force_enable <= avs_writedata[bank_sel_pkg::CTRL_FEN];
          cfg_q.used_cnt <=
            avs_writedata[bank_sel_pkg::CTRL_CNT +: bank_sel_pkg::BW];
        end
        bank_sel_pkg::ADR_FORCE:  force_code_q  <= wcode;
        bank_sel_pkg::ADR_REMOTE: remote_code_q <= wcode;
        bank_sel_pkg::ADR_MASK:   mask_q <= avs_writedata[bank_sel_pkg::EW-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------
  assign evt_clr = (wr_go && (avs_address == bank_sel_pkg::ADR_EVT)) ?
                   avs_writedata[bank_sel_pkg::EW-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      evt_q <= '0;
      irq_q <= 1'b0;
    end else begin
      // A set in the clearing cycle survives
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      irq_q <= |(evt_q & mask_q);
    end
  end

  // ----------------------------------------------------------
  // Bus slave: fixed one wait state per access
  // ----------------------------------------------------------
  always_comb begin
    rdata_mux = '0;
    case (avs_address)
      bank_sel_pkg::ADR_CTRL: begin
        rdata_mux[bank_sel_pkg::CTRL_FEN] = cfg_q.force_enable;
        rdata_mux[bank_sel_pkg::CTRL_CNT +: bank_sel_pkg::BW] = cfg_q.used_cnt;
      end
      bank_sel_pkg::ADR_FORCE:  rdata_mux[bank_sel_pkg::CW-1:0] = force_code_q;
      bank_sel_pkg::ADR_REMOTE: rdata_mux[bank_sel_pkg::CW-1:0] = remote_code_q;
      bank_sel_pkg::ADR_ACTIVE: rdata_mux[bank_sel_pkg::BW-1:0] = active_q;
      bank_sel_pkg::ADR_EVT:    rdata_mux[bank_sel_pkg::EW-1:0] = evt_q;
      bank_sel_pkg::ADR_MASK:   rdata_mux[bank_sel_pkg::EW-1:0] = mask_q;
      default:                  rdata_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (rd_go) begin
        rdata_q <= rdata_mux;
      end
    end
  end

  assign avs_readdata       = rdata_q;
  assign avs_waitrequest    = wait_q;
  assign active_bank        = active_q;
  assign bank_defaults_load = load_q;
  assign irq                = irq_q;
endmodule
`default_nettype wire

// File: sim/bank_sel_asserts.sv
// Port assertions for the parameter bank selector
`default_nettype none
module bank_sel_asserts (
  input wire logic                        clk_sys,
  input wire logic                        resetn,
  input wire logic [bank_sel_pkg::NB-1:0] bank_req,
  input wire logic [bank_sel_pkg::AW-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [bank_sel_pkg::DW-1:0] avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic [bank_sel_pkg::BW-1:0] active_bank,
  input wire logic [bank_sel_pkg::NB-1:0] bank_defaults_load
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_ask;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Six calm cycles let the sync chain and any write effect drain
  sequence s_quiet;
    (bank_req == 8'h00 && !avs_write) [*6];
  endsequence
  a_bus_answer: assert property (s_ask |=> !avs_waitrequest)
    else $error("access not answered");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("wait low when idle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h14
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_reset_bank: assert property ($rose(resetn) |-> active_bank == bank_sel_pkg::BANK_ONE)
    else $error("active bank not one after reset");
  a_active_read: assert property (avs_read && !avs_waitrequest
    && avs_address == bank_sel_pkg::ADR_ACTIVE |-> avs_readdata[31:3] == 29'h0
    && (avs_readdata[2:0] == active_bank || avs_readdata[2:0] == $past(active_bank)))
    else $error("active readback wrong");
  a_bank_holds: assert property (s_quiet |=> $stable(active_bank))
    else $error("active bank moved without request");
  a_load_pulse: assert property (|bank_defaults_load |=> bank_defaults_load == 8'h00)
    else $error("defaults load wider than one cycle");
  a_load_cause: assert property (|bank_defaults_load |-> !bank_defaults_load[0]
    && ($past(avs_write) || $past(avs_write, 2))) else $error("defaults load without write");
endmodule
bind parameter_bank_selector bank_sel_asserts chk (.clk_sys(clk_sys), .resetn(resetn),
  .bank_req(bank_req), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .active_bank(active_bank), .bank_defaults_load(bank_defaults_load));
`default_nettype wire

// File: sim/relay_inputs.sv
// Relay logic model driving the bank request pins
`default_nettype none
module relay_inputs (
  input  wire logic                        clk_sys,
  output var  logic [bank_sel_pkg::NB-1:0] bank_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bank_req = 8'h00;
  // Three cycles clears the input synchroniser with margin
  task automatic pulse(input int i);
    @(posedge clk_sys) bank_req[i] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bank_req[i] <= 1'b0;
  endtask
  task automatic level(input int i, input logic v);
    @(posedge clk_sys) bank_req[i] <= v;
  endtask
endmodule
`default_nettype wire

// File: sim/parameter_bank_selector_bench.sv
// Self-checking bench for the parameter bank selector
`default_nettype none
module parameter_bank_selector_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = bank_sel_pkg::ADR_CTRL;
  localparam logic [7:0] FO = bank_sel_pkg::ADR_FORCE;
  localparam logic [7:0] RM = bank_sel_pkg::ADR_REMOTE;
  localparam logic [7:0] EV = bank_sel_pkg::ADR_EVT;
  localparam logic [7:0] MK = bank_sel_pkg::ADR_MASK;
  localparam logic [7:0] REGS [7] = '{CT, FO, RM, 8'h0C, EV, MK, 8'h20};
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  bank_req;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  active_bank;
  logic [7:0]  bank_defaults_load;
  logic [7:0]  loads_seen = 8'h00;
  logic        irq;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checks = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) loads_seen <= loads_seen | bank_defaults_load;
  relay_inputs relay (.clk_sys(clk_sys), .bank_req(bank_req));
  parameter_bank_selector dut (.clk_sys(clk_sys), .resetn(resetn), .bank_req(bank_req),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .active_bank(active_bank),
    .bank_defaults_load(bank_defaults_load), .irq(irq));
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that samples wait low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic ev(input logic [31:0] e);
    chk(EV, e);
    wr(EV, 32'h1F);
  endtask
  task automatic act(input logic [31:0] e);
    repeat (8) @(posedge clk_sys);
    chk(8'h0C, e);
    cmp(32'(active_bank), e);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (REGS[i]) chk(REGS[i], 32'h0);
    avs_byteenable <= 4'hE;
    wr(CT, 32'h71);
    avs_byteenable <= 4'hF;
    chk(CT, 32'h0);
    relay.pulse(1); act(0); ev(32'h01);
    wr(CT, 32'h70); act(0); cmp(32'(loads_seen), 32'hFE); ev(32'h10);
    relay.pulse(2); act(2); ev(32'h08);
    wr(FO, 32'h5); act(2); ev(32'h02);
    relay.level(1, 1'b1); act(1); ev(32'h08);
    wr(MK, 32'h04); relay.pulse(4); act(1); cmp(32'(irq), 32'h1); ev(32'h04);
    relay.pulse(0); act(0); cmp(32'(irq), 32'h0); ev(32'h08);
    relay.level(1, 1'b0); relay.level(7, 1'b1); act(7); ev(32'h08);
    relay.pulse(3); act(3); ev(32'h08); relay.level(7, 1'b0);
    wr(CT, 32'h71); wr(FO, 32'h5); act(4); ev(32'h08);
    relay.pulse(2); act(4); ev(32'h00);
    wr(FO, 32'h9); act(4); ev(32'h01);
    wr(FO, 32'h0); act(4); ev(32'h00);
    relay.level(1, 1'b1); act(4); ev(32'h00);
    wr(RM, 32'h6); act(4); ev(32'h04);
    wr(RM, 32'h1); act(0); ev(32'h08); chk(RM, 32'h1);
    wr(CT, 32'h70); act(1); ev(32'h08); relay.level(1, 1'b0);
    relay.level(0, 1'b1); act(0); ev(32'h08);
    relay.pulse(7); act(0); ev(32'h04); relay.level(0, 1'b0);
    give_verdict();
  end
  initial begin
    #60000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
